/* rtl/pbc_pkg.sv */
/*
  shared constants and command encoding for the bank precharge control ends.
  assumes one 200 MHz clock shared by both ends.
*/
package pbc_pkg;

  // ----------------------------------------------------------------
  // clock and array shape
  // ----------------------------------------------------------------
  localparam int TCK_PS = 5000;
  localparam int NBANK = 8;
  localparam int BANK_W = 3;
  localparam int CA_W = 6;
  localparam int FLAG_BIT = 5;
  localparam int BANK_LSB = 0;
  localparam int CNT_W = 8;
  localparam int BL = 16;
  localparam int WL = 8;
  localparam int PF_WORDS = 16;
  localparam int GRP_CLK = PF_WORDS / 2;

  // ----------------------------------------------------------------
  // analog times in ps and derived cycle counts
  // ----------------------------------------------------------------
  localparam int T_RPPB_PS = 18000;
  localparam int T_RPAB_PS = 21000;
  localparam int T_RTP_PS = 7500;
  localparam int T_WR_PS = 18000;
  localparam int T_RAS_PS = 42000;

  function automatic int cyc_up(input int ps);
    return (ps + TCK_PS - 1) / TCK_PS;
  endfunction : cyc_up

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : imax

  localparam int N_RPPB = cyc_up(T_RPPB_PS);
  localparam int N_RPAB = cyc_up(T_RPAB_PS);
  localparam int N_RTP = cyc_up(T_RTP_PS);
  localparam int N_WR = cyc_up(T_WR_PS);
  localparam int N_RAS = cyc_up(T_RAS_PS);

  // ----------------------------------------------------------------
  // command spacings in cycles
  // ----------------------------------------------------------------
  localparam int RD_PRE = imax(BL / 2, BL / 2 - 8 + N_RTP);
  localparam int RD_AC = imax(BL / 2, BL / 4 - 4 + N_RTP);
  localparam int WR_END = WL + BL / 2;
  localparam int WR_PRE = WR_END + 1 + N_WR;
  localparam int WR_CCD = BL / 2;
  localparam int AC_LAT = 1;

  typedef enum logic [2:0] {OP_DES, OP_ACT, OP_RD, OP_WR, OP_PRE} pbc_op_t;

endpackage : pbc_pkg

/* rtl/pbc_cmd_if.sv */
/*
  command bus between controller end and device end.
  assumes both ends run on the same clock; each command is two beats.
*/
`timescale 1ns/1ps
interface pbc_cmd_if;
  import pbc_pkg::*;
  logic cs;
  pbc_op_t op;
  logic [CA_W-1:0] ca;
  modport dev (input cs, input op, input ca);
  modport ctl (output cs, output op, output ca);
endinterface : pbc_cmd_if

/* rtl/pbc_bank_dev.sv */
/*
  device end: decodes two-beat commands, tracks open banks, precharge
  timing, auto-close and write prefetch group commits.
  assumes the controller end keeps every spacing it is bound to.
*/
`timescale 1ns/1ps

// Functional notes
// - precharge closes one bank or all eight
// - flag on bit 5, bank on bits 2..0
// - bank ready after per-bank or all-bank time
// - all-bank precharge time exceeds per-bank time
// - controller waits half burst after read
// - controller waits row active time before precharge
// - controller waits precharge time before activate
// - read-to-precharge time starts at BL/2-8
// - read-to-precharge also meets absolute time
// - write recovery before precharge after write
// - write commits in 16-word prefetch groups
// - write-to-precharge is WL+BL/2+1+recovery
// - bank closed before opening another row
// - read/write bit 5 is auto-close flag
// - flag clear leaves bank open
// - flag set starts internal precharge
// - writes may use extra gaps, postamble choice
// - any valid command between spaced writes
// - writes spaced at least half burst
// - read auto-close at later of two points
// - write auto-close after recovery past burst
module pbc_bank_dev
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // command bus
  pbc_cmd_if.dev cmd,
  // bank status
  output logic [NBANK-1:0] bank_open_o,
  output logic [NBANK-1:0] bank_ready_o,
  output logic [NBANK-1:0] close_start_o,
  // write group commit
  output logic wr_commit_o
);

  // ----------------------------------------------------------------
  // two-beat command capture
  // ----------------------------------------------------------------
  logic beat2_q;
  pbc_op_t op_q;
  logic flag_q;
  logic exec;
  logic [BANK_W-1:0] bank_sel;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      beat2_q <= 1'b0;
    end
    else
    begin
      beat2_q <= cmd.cs && !beat2_q;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      op_q <= OP_DES;
      flag_q <= 1'b0;
    end
    else if (cmd.cs && !beat2_q)
    begin
      op_q <= cmd.op;
      flag_q <= cmd.ca[FLAG_BIT];
    end
  end

  assign exec = beat2_q;
  assign bank_sel = cmd.ca[BANK_LSB +: BANK_W];

  // ----------------------------------------------------------------
  // write prefetch group tracking
  // ----------------------------------------------------------------
  logic [WR_END-1:0] wdly_q;
  logic grp_end;

  // delay line so back-to-back writes each get their own commit
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wdly_q <= '0;
    end
    else
    begin
      wdly_q <= {wdly_q[WR_END-2:0], exec && (op_q == OP_WR)};
    end
  end

  // one tap per prefetch group, last tap at burst end
  always_comb
  begin
    grp_end = 1'b0;
    for (int g = 0; g < BL / PF_WORDS; g++)
    begin
      grp_end = grp_end | wdly_q[WR_END - 1 - g * GRP_CLK];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_commit_o <= 1'b0;
    end
    else
    begin
      wr_commit_o <= grp_end;
    end
  end

  // ----------------------------------------------------------------
  // per-bank state
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < NBANK; b++)
    begin : g_bank
      logic open_q;
      logic [CNT_W-1:0] rp_q;
      logic [CNT_W-1:0] ac_q;
      logic ac_pend_q;
      logic hit;
      logic pre_hit;
      logic ac_fire;
      logic close_now;
      logic close_ab;

      assign hit = exec && (bank_sel == BANK_W'(b));
      // all-bank flag ignores the bank bits
      assign pre_hit = exec && (op_q == OP_PRE) && (flag_q || bank_sel == BANK_W'(b));
      assign ac_fire = ac_pend_q && (ac_q == '0);
      // idle bank: precharge accepted, nothing changes
      assign close_now = (pre_hit && open_q) || ac_fire;
      assign close_ab = pre_hit && flag_q;

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          open_q <= 1'b0;
        end
        else if (hit && op_q == OP_ACT && rp_q == '0)
        begin
          open_q <= 1'b1;
        end
        else if (close_now)
        begin
          open_q <= 1'b0;
        end
      end

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          rp_q <= '0;
        end
        else if (close_now)
        begin
          rp_q <= close_ab ? CNT_W'(N_RPAB) : CNT_W'(N_RPPB);
        end
        else if (rp_q != '0)
        begin
          rp_q <= rp_q - 1'b1;
        end
      end

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          ac_pend_q <= 1'b0;
          ac_q <= '0;
        end
        else if (hit && op_q == OP_RD && open_q)
        begin
          ac_pend_q <= flag_q;
          ac_q <= CNT_W'(RD_AC - 1);
        end
        else if (hit && op_q == OP_WR && open_q)
        begin
          ac_pend_q <= flag_q;
          ac_q <= CNT_W'(WR_PRE - 1);
        end
        else if (ac_fire || pre_hit)
        begin
          ac_pend_q <= 1'b0;
        end
        else if (ac_q != '0)
        begin
          ac_q <= ac_q - 1'b1;
        end
      end

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          close_start_o[b] <= 1'b0;
        end
        else
        begin
          close_start_o[b] <= close_now;
        end
      end

      assign bank_open_o[b] = open_q;
      assign bank_ready_o[b] = !open_q && (rp_q == '0);
    end
  endgenerate

endmodule : pbc_bank_dev

/* rtl/pbc_bank_ctl.sv */
/*
  controller end: takes user requests, holds them until every spacing is met, but
  takes a precharge to a bank closed by an auto-close read or write at once, and
  drives two-beat commands onto the command bus.
  assumes the device end shares clk_i.
*/
`timescale 1ns/1ps
module pbc_bank_ctl
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // user request
  input wire logic req_valid_i,
  input wire pbc_op_t req_op_i,
  input wire logic [BANK_W-1:0] req_bank_i,
  input wire logic req_flag_i,
  output logic req_ready_o,
  // bank view
  output logic [NBANK-1:0] bank_open_o,
  // command bus
  pbc_cmd_if.ctl cmd
);

  // ----------------------------------------------------------------
  // legality check
  // ----------------------------------------------------------------
  logic phase_q;
  logic [CNT_W-1:0] wccd_q;
  logic [NBANK-1:0] pre_ok;
  logic [NBANK-1:0] act_ok;
  logic legal;
  logic take;

  always_comb
  begin
    case (req_op_i)
      OP_ACT: legal = !bank_open_o[req_bank_i] && act_ok[req_bank_i];
      OP_RD: legal = bank_open_o[req_bank_i];
      OP_WR: legal = bank_open_o[req_bank_i] && (wccd_q == '0);
      OP_PRE: legal = req_flag_i ? (&pre_ok) : pre_ok[req_bank_i];
      default: legal = 1'b1;
    endcase
  end

  assign req_ready_o = !phase_q && legal;
  assign take = req_valid_i && req_ready_o;

  // ----------------------------------------------------------------
  // command drive
  // ----------------------------------------------------------------
  logic [BANK_W-1:0] bank_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_q <= 1'b0;
      bank_q <= '0;
      cmd.cs <= 1'b0;
      cmd.op <= OP_DES;
      cmd.ca <= '0;
    end
    else if (take && req_op_i != OP_DES)
    begin
      phase_q <= 1'b1;
      bank_q <= req_bank_i;
      cmd.cs <= 1'b1;
      cmd.op <= req_op_i;
      cmd.ca <= CA_W'(req_flag_i) << FLAG_BIT;
    end
    else if (phase_q)
    begin
      phase_q <= 1'b0;
      cmd.cs <= 1'b0;
      cmd.ca <= CA_W'(bank_q) << BANK_LSB;
    end
    else
    begin
      cmd.cs <= 1'b0;
      cmd.op <= OP_DES;
      cmd.ca <= '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wccd_q <= '0;
    end
    else if (take && req_op_i == OP_WR)
    begin
      wccd_q <= CNT_W'(WR_CCD - 1);
    end
    else if (wccd_q != '0)
    begin
      wccd_q <= wccd_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // per-bank timers
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < NBANK; b++)
    begin : g_bank
      logic open_q;
      logic [CNT_W-1:0] ras_q;
      logic [CNT_W-1:0] pre_q;
      logic [CNT_W-1:0] act_q;
      logic sel;

      assign sel = take && (req_bank_i == BANK_W'(b));
      assign pre_ok[b] = !open_q || (ras_q == '0 && pre_q == '0);
      assign act_ok[b] = (act_q == '0);
      assign bank_open_o[b] = open_q;

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          open_q <= 1'b0;
          ras_q <= '0;
          pre_q <= '0;
          act_q <= '0;
        end
        else
        begin
          ras_q <= (ras_q != '0) ? ras_q - 1'b1 : ras_q;
          pre_q <= (pre_q != '0) ? pre_q - 1'b1 : pre_q;
          act_q <= (act_q != '0) ? act_q - 1'b1 : act_q;
          if (sel && req_op_i == OP_ACT)
          begin
            open_q <= 1'b1;
            ras_q <= CNT_W'(N_RAS);
          end
          else if (sel && req_op_i == OP_RD)
          begin
            if (pre_q < CNT_W'(RD_PRE))
            begin
              pre_q <= CNT_W'(RD_PRE);
            end
            if (req_flag_i)
            begin
              open_q <= 1'b0;
              act_q <= CNT_W'(RD_AC + AC_LAT + N_RPPB);
            end
          end
          else if (sel && req_op_i == OP_WR)
          begin
            pre_q <= CNT_W'(WR_PRE);
            if (req_flag_i)
            begin
              open_q <= 1'b0;
              act_q <= CNT_W'(WR_PRE + AC_LAT + N_RPPB);
            end
          end
          else if (take && req_op_i == OP_PRE && open_q && (req_flag_i || sel))
          begin
            open_q <= 1'b0;
            act_q <= req_flag_i ? CNT_W'(N_RPAB + AC_LAT) : CNT_W'(N_RPPB + AC_LAT);
          end
        end
      end
    end
  endgenerate

endmodule : pbc_bank_ctl

/* sim/pbc_checker.sv */
/*
  assertions on the command bus and device bank status.
  assumes one clock, reset high, signals taken from the interface and device ports.
*/
`timescale 1ns/1ps
module pbc_checker
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // command bus
  input wire logic cs,
  input wire pbc_op_t op,
  input wire logic [CA_W-1:0] ca,
  // device status
  input wire logic [NBANK-1:0] bank_open_o,
  input wire logic [NBANK-1:0] bank_ready_o,
  input wire logic [NBANK-1:0] close_start_o,
  input wire logic wr_commit_o
);
  localparam int RDA = RD_AC + 1;
  localparam int WRA = WR_PRE + 1;
  localparam int WCA = WR_END + 1;
  logic beat2_q;
  logic flag_q;
  logic [CNT_W-1:0] gap_q [5];
  logic [BANK_W-1:0] bk_q [5];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // beat tracking and gaps since each op
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      beat2_q <= 1'h0;
      flag_q <= 1'h0;
    end
    else
    begin
      beat2_q <= cs;
      flag_q <= ca[FLAG_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (rst_i)
      begin
        gap_q[i] <= '1;
        bk_q[i] <= '0;
      end
      else if (beat2_q && op == pbc_op_t'(i))
      begin
        gap_q[i] <= 8'h01;
        bk_q[i] <= ca[BANK_W-1:0];
      end
      else if (gap_q[i] != '1)
        gap_q[i] <= gap_q[i] + 8'h01;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_CS_PULSE: assert property (cs |=> !cs)
    else $error("cs held past one cycle");
  AST_PRE_ONE: assert property (beat2_q && op == OP_PRE && !flag_q |=> !bank_open_o[bk_q[OP_PRE]])
    else $error("single bank not closed");
  AST_PRE_ALL: assert property (beat2_q && op == OP_PRE && flag_q |=> bank_open_o == '0)
    else $error("all banks not closed");
  AST_RDY_WAIT: assert property (close_start_o[0] |-> !bank_ready_o[0] [*3] ##[1:3] bank_ready_o[0])
    else $error("bank 0 ready timing wrong");
  AST_WR_SPACE: assert property (beat2_q && op == OP_WR |-> gap_q[OP_WR] >= WR_CCD)
    else $error("writes too close");
  AST_RD_PRE: assert property (beat2_q && op == OP_PRE && (flag_q || ca[BANK_W-1:0] == bk_q[OP_RD])
    |-> gap_q[OP_RD] >= RD_PRE)
    else $error("precharge too soon after read");
  AST_WR_PRE: assert property (beat2_q && op == OP_PRE && (flag_q || ca[BANK_W-1:0] == bk_q[OP_WR])
    |-> gap_q[OP_WR] >= WR_PRE)
    else $error("precharge too soon after write");
  AST_RAS: assert property (beat2_q && op == OP_PRE && (flag_q || ca[BANK_W-1:0] == bk_q[OP_ACT])
    |-> gap_q[OP_ACT] >= N_RAS)
    else $error("precharge before row active time");
  AST_ACT_OK: assert property (beat2_q && op == OP_ACT |-> !bank_open_o[ca[BANK_W-1:0]]
    && (ca[BANK_W-1:0] != bk_q[OP_PRE] || gap_q[OP_PRE] >= N_RPPB))
    else $error("activate to open or precharging bank");
  AST_RD_OPEN: assert property (beat2_q && op == OP_RD && !flag_q |=> bank_open_o[bk_q[OP_RD]] [*8])
    else $error("bank closed after plain read");
  AST_RD_AC: assert property (beat2_q && op == OP_RD && flag_q |-> ##RDA close_start_o[bk_q[OP_RD]])
    else $error("read auto-close at wrong cycle");
  AST_WR_AC: assert property (beat2_q && op == OP_WR && flag_q |-> ##WRA close_start_o[bk_q[OP_WR]])
    else $error("write auto-close at wrong cycle");
  AST_WR_COMMIT: assert property (beat2_q && op == OP_WR |-> ##WCA wr_commit_o)
    else $error("write group commit missing");
  cover property (beat2_q && op == OP_PRE && flag_q);
  cover property (beat2_q && op == OP_RD && flag_q);
  cover property (beat2_q && op == OP_WR && flag_q);
endmodule : pbc_checker

/* sim/tb_top.sv */
/*
  top testbench: both ends joined by the command interface, driven by user requests.
  assumes a 200 MHz clock and reset held 10 cycles.
*/
`timescale 1ns/1ps
module tb_top
  import pbc_pkg::*;
;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic req_valid_i = 1'h0;
  pbc_op_t req_op_i = OP_DES;
  logic [BANK_W-1:0] req_bank_i = 3'h0;
  logic req_flag_i = 1'h0;
  logic req_ready_o;
  logic [NBANK-1:0] ctl_open;
  logic [NBANK-1:0] bank_open_o;
  logic [NBANK-1:0] bank_ready_o;
  logic [NBANK-1:0] close_start_o;
  logic wr_commit_o;
  int miscompares = 0;
  int total_checks = 0;
  int commits = 0;
  int cyc = 0;
  int n;
  int t1;
  int t2;

  pbc_cmd_if u_pbc_cmd_if ();
  pbc_bank_ctl u_pbc_bank_ctl (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
    .req_bank_i(req_bank_i), .req_flag_i(req_flag_i), .req_ready_o(req_ready_o), .bank_open_o(ctl_open),
    .cmd(u_pbc_cmd_if.ctl));
  pbc_bank_dev u_pbc_bank_dev (.clk_i(clk_i), .rst_i(rst_i), .cmd(u_pbc_cmd_if.dev), .bank_open_o(bank_open_o),
    .bank_ready_o(bank_ready_o), .close_start_o(close_start_o), .wr_commit_o(wr_commit_o));
  pbc_checker u_pbc_checker (.clk_i(clk_i), .rst_i(rst_i), .cs(u_pbc_cmd_if.cs), .op(u_pbc_cmd_if.op),
    .ca(u_pbc_cmd_if.ca), .bank_open_o(bank_open_o), .bank_ready_o(bank_ready_o),
    .close_start_o(close_start_o), .wr_commit_o(wr_commit_o));

  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (wr_commit_o === 1'h1)
      commits <= commits + 1;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic issue(input pbc_op_t o, input int b, input logic f);
    int k;
    @(posedge clk_i);
    req_op_i <= o;
    req_bank_i <= b[BANK_W-1:0];
    req_flag_i <= f;
    req_valid_i <= 1'h1;
    k = 0;
    @(negedge clk_i);
    while (req_ready_o !== 1'h1 && k < 200)
    begin
      k++;
      @(negedge clk_i);
    end
    if (k >= 200)
    begin
      miscompares++;
      give_verdict();
    end
    else
    begin
      @(posedge clk_i);
      req_valid_i <= 1'h0;
    end
  endtask : issue

  function automatic logic sig(input int kind, input int b);
    return kind == 0 ? bank_ready_o[b] : (kind == 1 ? bank_open_o[b] : close_start_o[b]);
  endfunction : sig

  // kind 0 ready, 1 open, 2 close start
  task automatic wait_on(input int b, input logic want, input int kind, output int cnt);
    cnt = 0;
    @(negedge clk_i);
    while (sig(kind, b) !== want && cnt < 300)
    begin
      cnt++;
      @(negedge clk_i);
    end
    if (cnt >= 300)
    begin
      miscompares++;
      give_verdict();
    end
  endtask : wait_on

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    @(negedge clk_i);
    check(bank_open_o, 8'h00);
    check(bank_ready_o, 8'hFF);
    for (int i = 0; i < NBANK; i++)
      issue(OP_ACT, i, 1'h0);
    repeat (4) @(negedge clk_i);
    check(bank_open_o, 8'hFF);
    check(ctl_open, 8'hFF);
    issue(OP_PRE, 2, 1'h0);
    wait_on(2, 1'h1, 2, n);
    check(bank_open_o, 8'hFB);
    wait_on(2, 1'h1, 0, t1);
    issue(OP_PRE, 2, 1'h0);
    repeat (6) @(negedge clk_i);
    check({bank_open_o, bank_ready_o[2]}, 16'h01F7);
    // bank bits set but ignored
    issue(OP_PRE, 5, 1'h1);
    wait_on(0, 1'h1, 2, n);
    check(bank_open_o, 8'h00);
    wait_on(0, 1'h1, 0, t2);
    check(t2 - t1, N_RPAB - N_RPPB);
    issue(OP_ACT, 1, 1'h0);
    issue(OP_RD, 1, 1'h0);
    repeat (30) @(negedge clk_i);
    check(bank_open_o[1], 1'h1);
    issue(OP_RD, 1, 1'h1);
    wait_on(1, 1'h0, 1, n);
    check(n, RD_AC + 2);
    issue(OP_ACT, 3, 1'h0);
    t2 = commits;
    issue(OP_WR, 3, 1'h0);
    issue(OP_WR, 3, 1'h0);
    t1 = cyc;
    issue(OP_PRE, 3, 1'h0);
    check(cyc - t1 >= WR_PRE, 1'h1);
    wait_on(3, 1'h0, 1, n);
    check(n, 2);
    check(commits - t2, 2);
    issue(OP_ACT, 4, 1'h0);
    t1 = commits;
    issue(OP_WR, 4, 1'h1);
    wait_on(4, 1'h0, 1, n);
    check(n, WR_PRE + 2);
    check(commits - t1, 1);
    repeat (4) @(negedge clk_i);
    give_verdict();
  end
endmodule : tb_top
